// ---- verilog/aacr_pkg.sv ----
// constants, types and carriers of the amplifier configuration register bank
// assumes one synchronous register port driven by a control-bus front end
package aacr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SERIAL_PORT = 8'h03; // serial_port_setup
  localparam logic [7:0] ADDR_CHANNEL_STATE = 8'h04; // channel_state_select
  localparam logic [7:0] ADDR_VOLUME_FIRST = 8'h05; // channel1_volume
  localparam logic [7:0] ADDR_VOLUME_LAST = 8'h08; // channel4_volume
  localparam logic [7:0] ADDR_LOAD_CHECK = 8'h09; // load_check_control
  localparam logic [7:0] ADDR_THRESH_CH12 = 8'h0a; // short_threshold_ch12
  localparam logic [7:0] ADDR_THRESH_CH34 = 8'h0b; // short_threshold_ch34

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SERIAL_PORT = 8'h04; // i2s, 44.1 khz
  localparam logic [7:0] RST_CHANNEL_STATE = 8'h55; // all high impedance
  localparam logic [7:0] RST_VOLUME = 8'hcf; // 0 db
  localparam logic [7:0] RST_LOAD_CHECK = 8'h00; // all off
  localparam logic [7:0] RST_THRESH = 8'h11; // 1 ohm on both channels

  // ----------------------------------------------------------------
  // field positions and limits
  // ----------------------------------------------------------------
  localparam int CHANNELS = 4; // amplifier channels
  localparam int STATE_FIELD_W = 2; // state bits per channel
  localparam int THRESH_FIELD_W = 4; // threshold bits per channel
  localparam int ABORT_BIT = 7; // diag_abort in load_check_control
  localparam logic [7:0] VOLUME_MUTE_BELOW = 8'h07; // lowest audible code
  localparam logic [3:0] THRESH_MAX = 4'h9; // 5 ohm, last defined code
  localparam logic [2:0] FS_DIV_ONE = 3'h0; // last count at 1 frame_sync/step
  localparam logic [1:0] RATE_SEL_ZERO = 2'h0; // ramp rate field origin

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_44K1 = 2'b00,
    RATE_48K = 2'b01,
    RATE_96K = 2'b10,
    RATE_RESERVED = 2'b11
  } aacr_rate_type;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'b000,
    FMT_RJ20 = 3'b001,
    FMT_RJ18 = 3'b010,
    FMT_RJ16 = 3'b011,
    FMT_I2S = 3'b100,
    FMT_LJ = 3'b101,
    FMT_DSP = 3'b110,
    FMT_RESERVED = 3'b111
  } aacr_format_type;

  typedef enum logic [1:0] {
    MODE_PLAY = 2'b00,
    MODE_HIGH_IMPEDANCE = 2'b01,
    MODE_MUTE = 2'b10,
    MODE_LOAD_CHECK = 2'b11
  } aacr_chan_mode_type;

  // ----------------------------------------------------------------
  // carriers; bit order matches the register layout exactly
  // ----------------------------------------------------------------
  typedef struct packed {
    aacr_rate_type sample_rate_sel; // bits 7-6
    logic slot_half_select; // bit 5, 1 = last four slots
    logic slot_size_16; // bit 4, 1 = 16-bit slots
    logic slot_swap; // bit 3, 1 = swapped
    aacr_format_type input_format; // bits 2-0
  } aacr_serial_cfg_type;

  typedef struct packed {
    logic diag_abort; // bit 7
    logic double_ramp; // bit 6
    logic double_settle; // bit 5
    logic [2:0] spare; // bits 4-2, stored only
    logic line_out_check_en; // bit 1
    logic auto_check_skip; // bit 0
  } aacr_diag_cfg_type;

  typedef struct packed {
    logic wr_en; // write strobe, one cycle
    logic rd_en; // read strobe, one cycle
    logic [7:0] addr; // register offset
    logic [7:0] wr_data; // write byte
  } aacr_reg_req_type;

  typedef struct packed {
    logic rd_valid; // read answer marker
    logic [7:0] rd_data; // read byte
  } aacr_reg_rsp_type;

endpackage

// ---- verilog/aacr_volume_ramp.sv ----
// one channel of gradual volume movement toward a written gain code
// assumes step_en is a one-cycle pulse from the frame-sync divider
`timescale 1ns/1ps

module aacr_volume_ramp import aacr_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic step_en,
  input wire logic [7:0] target,
  output logic [7:0] gain,
  output logic mute
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] gain; // applied gain code
    logic mute; // applied code below audible range
  } aacr_ramp_state_type;

  aacr_ramp_state_type st; // registered state
  aacr_ramp_state_type next_st; // next state

  // one code (0.5 db) per step toward the target
  always_comb begin
    next_st = st;
    if (step_en) begin
      if (st.gain < target) begin
        next_st.gain = st.gain + 8'h01;
      end else if (st.gain > target) begin
        next_st.gain = st.gain - 8'h01;
      end
    end
    next_st.mute = next_st.gain < VOLUME_MUTE_BELOW;
  end

  // state register, reset to 0 db unmuted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{gain: RST_VOLUME, mute: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign gain = st.gain;
  assign mute = st.mute;

endmodule // aacr_volume_ramp

// ---- verilog/aacr_config_regs.sv ----
// configuration register bank of a four-channel digital audio amplifier
// assumes a control-bus front end that presents one byte access per strobe,
// a frame-sync pulse from the serial port and per-channel fault levels
`timescale 1ns/1ps

// What this block does
// - sample-rate field selects 44.1, 48, 96 kHz
// - slot-half bit picks first or last four slots
// - slot-size bit selects 16-bit versus wider slots
// - slot-swap bit selects swapped slot assignment
// - format field selects justified, i2s, dsp formats
// - two-bit state field per channel, four modes
// - state register resets to all high impedance
// - four volume registers at offsets 0x05-0x08
// - half-db volume codes, below 0x07 mutes
// - writing abort bit stops running diagnostic
// - bits six and five double ramp, settle
// - bit one enables line-output diagnostics
// - skip bit blocks automatic diagnostic starts
// - four-bit shorted-load threshold per channel, reset 1 ohm
// - volume moves one step per 1-8 frames
module aacr_config_regs import aacr_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire aacr_reg_req_type REG_REQ,
  output aacr_reg_rsp_type REG_RSP,
  input wire logic FRAME_SYNC,
  input wire logic [1:0] VOLUME_STEP_RATE,
  input wire logic [3:0] CH_FAULT,
  output aacr_serial_cfg_type SERIAL_CFG,
  output logic SERIAL_CFG_RESERVED,
  output logic [7:0] CH_STATE_SEL,
  output logic [31:0] CH_GAIN,
  output logic [3:0] CH_MUTE,
  output aacr_diag_cfg_type DIAG_CFG,
  output logic DIAG_ABORT_PULSE,
  output logic [3:0] DIAG_START,
  output logic [15:0] SHORT_THRESHOLD,
  output logic [3:0] SHORT_THRESHOLD_RESERVED
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] serial_port_setup; // serial audio port fields
    logic [7:0] channel_state_select; // per-channel mode request
    logic [3:0][7:0] channel_volume; // target gain codes, ch1 at [0]
    logic [7:0] load_check_control; // diagnostic control
    logic [7:0] short_threshold_ch12; // ch1 high nibble, ch2 low
    logic [7:0] short_threshold_ch34; // ch3 high nibble, ch4 low
    aacr_reg_rsp_type rsp; // read answer
    logic [2:0] fs_count; // frame syncs seen since last step
    logic step_en; // one-cycle ramp step
    logic [3:0] fault_prev; // fault levels one cycle ago
    logic abort_pulse; // abort written this cycle
    logic [3:0] diag_start; // automatic or requested diag start
    logic serial_reserved; // reserved rate or format held
    logic [3:0] thresh_reserved; // reserved threshold code held
  } aacr_state_type;

  aacr_state_type st; // registered state
  aacr_state_type next_st; // next state
  logic [3:0][7:0] ramp_gain; // applied gain per channel
  logic [3:0] ramp_mute; // applied mute per channel

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // mode field of one channel; ch1 sits in the top two bits
  function automatic aacr_chan_mode_type mode_of(input logic [7:0] r, input int ch);
    logic [1:0] f;
    f = r[(CHANNELS - 1 - ch) * STATE_FIELD_W +: STATE_FIELD_W];
    return aacr_chan_mode_type'(f);
  endfunction

  // threshold nibble of one channel across the two threshold registers
  function automatic logic [3:0] thresh_of(input logic [15:0] r, input int ch);
    return r[(CHANNELS - 1 - ch) * THRESH_FIELD_W +: THRESH_FIELD_W];
  endfunction

  // last frame-sync count before a step: 0, 1, 3 or 7
  function automatic logic [2:0] fs_last(input logic [1:0] rate);
    logic [3:0] span;
    span = 4'h1 << rate;
    return 3'(span - 4'h1);
  endfunction

  // true when the byte lands on a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a >= ADDR_SERIAL_PORT) && (a <= ADDR_THRESH_CH34);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wd; // write byte
    logic [7:0] rd; // read byte
    logic [1:0] vidx; // volume register index
    logic skip; // automatic diagnostics bypassed
    logic [15:0] thr; // both threshold registers
    aacr_serial_cfg_type scfg; // serial setup, decoded view
    skip = 1'b0;
    thr = 16'h0000;
    scfg = '0;
    wd = REG_REQ.wr_data;
    rd = 8'h00;
    vidx = 2'(REG_REQ.addr - ADDR_VOLUME_FIRST);
    next_st = st;

    // one-cycle outputs fall unless set below
    next_st.rsp.rd_valid = 1'b0;
    next_st.abort_pulse = 1'b0;
    next_st.diag_start = 4'h0;
    next_st.step_en = 1'b0;

    // register writes; every field stores as written, reserved codes too
    if (REG_REQ.wr_en) begin
      case (REG_REQ.addr)
        ADDR_SERIAL_PORT: begin
          next_st.serial_port_setup = wd;
        end
        ADDR_CHANNEL_STATE: begin
          next_st.channel_state_select = wd;
        end
        ADDR_LOAD_CHECK: begin
          next_st.load_check_control = wd;
          // abort acts on the write of a one, not on the stored level
          next_st.abort_pulse = wd[ABORT_BIT];
        end
        ADDR_THRESH_CH12: begin
          next_st.short_threshold_ch12 = wd;
        end
        ADDR_THRESH_CH34: begin
          next_st.short_threshold_ch34 = wd;
        end
        default: begin
          // volume block is a contiguous range; anything else is dropped
          if (REG_REQ.addr >= ADDR_VOLUME_FIRST && REG_REQ.addr <= ADDR_VOLUME_LAST) begin
            next_st.channel_volume[vidx] = wd;
          end
        end
      endcase
    end

    // register reads return the value before a same-cycle write
    if (REG_REQ.rd_en) begin
      case (REG_REQ.addr)
        ADDR_SERIAL_PORT: begin
          rd = st.serial_port_setup;
        end
        ADDR_CHANNEL_STATE: begin
          rd = st.channel_state_select;
        end
        ADDR_LOAD_CHECK: begin
          rd = st.load_check_control;
        end
        ADDR_THRESH_CH12: begin
          rd = st.short_threshold_ch12;
        end
        ADDR_THRESH_CH34: begin
          rd = st.short_threshold_ch34;
        end
        default: begin
          // unmapped offsets read as zero but still answer
          if (is_mapped(REG_REQ.addr)) begin
            rd = st.channel_volume[vidx];
          end
        end
      endcase
      next_st.rsp.rd_valid = 1'b1;
      next_st.rsp.rd_data = rd;
    end

    // frame-sync divider for the volume ramp
    if (FRAME_SYNC) begin
      if (st.fs_count >= fs_last(VOLUME_STEP_RATE)) begin
        next_st.fs_count = FS_DIV_ONE;
        next_st.step_en = 1'b1;
      end else begin
        next_st.fs_count = st.fs_count + 3'h1;
      end
    end

    // automatic diagnostic starts, watched against the new register values
    skip = next_st.load_check_control[0];
    next_st.fault_prev = CH_FAULT;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // leaving high impedance, or a fresh fault, starts a check
      if (!skip) begin
        if (mode_of(st.channel_state_select, ch) == MODE_HIGH_IMPEDANCE
            && mode_of(next_st.channel_state_select, ch) != MODE_HIGH_IMPEDANCE) begin
          next_st.diag_start[ch] = 1'b1;
        end
        if (CH_FAULT[ch] && !st.fault_prev[ch]) begin
          next_st.diag_start[ch] = 1'b1;
        end
      end
      // an explicit diagnostic request starts one whatever the skip bit says
      if (mode_of(st.channel_state_select, ch) != MODE_LOAD_CHECK
          && mode_of(next_st.channel_state_select, ch) == MODE_LOAD_CHECK) begin
        next_st.diag_start[ch] = 1'b1;
      end
    end
    // no start while abort is held set; the host clears it first
    if (next_st.load_check_control[ABORT_BIT]) begin
      next_st.diag_start = 4'h0;
    end

    // reserved-code flags for the consumers of the fields
    scfg = aacr_serial_cfg_type'(next_st.serial_port_setup);
    next_st.serial_reserved = (scfg.sample_rate_sel == RATE_RESERVED)
      || (scfg.input_format == FMT_RESERVED);
    thr = {next_st.short_threshold_ch12, next_st.short_threshold_ch34};
    for (int ch = 0; ch < CHANNELS; ch++) begin
      next_st.thresh_reserved[ch] = thresh_of(thr, ch) > THRESH_MAX;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st.serial_port_setup <= RST_SERIAL_PORT;
      st.channel_state_select <= RST_CHANNEL_STATE;
      st.channel_volume <= {CHANNELS{RST_VOLUME}};
      st.load_check_control <= RST_LOAD_CHECK;
      st.short_threshold_ch12 <= RST_THRESH;
      st.short_threshold_ch34 <= RST_THRESH;
      st.rsp <= '0;
      st.fs_count <= FS_DIV_ONE;
      st.step_en <= 1'b0;
      st.fault_prev <= 4'h0;
      st.abort_pulse <= 1'b0;
      st.diag_start <= 4'h0;
      st.serial_reserved <= 1'b0;
      st.thresh_reserved <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // volume ramps, one per channel
  // ----------------------------------------------------------------
  // the ramp follows the target even in mute or high impedance, so a
  // later return to play resumes at the current code without a jump
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ramp
    aacr_volume_ramp u_ramp (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .step_en(st.step_en),
      .target(st.channel_volume[ch]),
      .gain(ramp_gain[ch]),
      .mute(ramp_mute[ch])
    );
  end

  // ----------------------------------------------------------------
  // outputs, all taken from flip-flops
  // ----------------------------------------------------------------
  assign REG_RSP = st.rsp;
  assign SERIAL_CFG = aacr_serial_cfg_type'(st.serial_port_setup);
  assign SERIAL_CFG_RESERVED = st.serial_reserved;
  assign CH_STATE_SEL = st.channel_state_select;
  assign CH_GAIN = ramp_gain;
  assign CH_MUTE = ramp_mute;
  assign DIAG_CFG = aacr_diag_cfg_type'(st.load_check_control);
  assign DIAG_ABORT_PULSE = st.abort_pulse;
  assign DIAG_START = st.diag_start;
  assign SHORT_THRESHOLD = {st.short_threshold_ch12, st.short_threshold_ch34};
  assign SHORT_THRESHOLD_RESERVED = st.thresh_reserved;

endmodule // aacr_config_regs

// ---- verification/aacr_config_regs_chk.sv ----
// assertion checker for the amplifier configuration register bank
// assumes it is bound to aacr_config_regs and sees only its ports
`timescale 1ns/1ps

module aacr_config_regs_chk import aacr_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire aacr_reg_req_type REG_REQ,
  input wire aacr_reg_rsp_type REG_RSP,
  input wire aacr_serial_cfg_type SERIAL_CFG,
  input wire logic SERIAL_CFG_RESERVED,
  input wire logic [7:0] CH_STATE_SEL,
  input wire logic [31:0] CH_GAIN,
  input wire logic [3:0] CH_MUTE,
  input wire aacr_diag_cfg_type DIAG_CFG,
  input wire logic DIAG_ABORT_PULSE,
  input wire logic [3:0] DIAG_START,
  input wire logic [15:0] SHORT_THRESHOLD,
  input wire logic [3:0] SHORT_THRESHOLD_RESERVED
);
  // ----------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  // ----------------------------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  logic [3:0] mute_exp; // mute worked out from shown gain
  logic [3:0] thr_exp; // reserved flag worked out from thresholds
  // per-channel flags; ch1 threshold sits in the top nibble
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mute_exp[i] = CH_GAIN[8*i +: 8] < VOLUME_MUTE_BELOW;
      thr_exp[i] = SHORT_THRESHOLD[12-4*i +: 4] > THRESH_MAX;
    end
  end
  // a write strobe at one offset
  sequence s_wr(a);
    REG_REQ.wr_en && REG_REQ.addr == a;
  endsequence
  // a volume write, then a read of it in the next cycle
  sequence s_vol_wr_rd;
    s_wr(ADDR_VOLUME_FIRST) ##1 (REG_REQ.rd_en && REG_REQ.addr == ADDR_VOLUME_FIRST);
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_read_answer: assert property (REG_REQ.rd_en |=> REG_RSP.rd_valid)
    else $error("read strobe got no answer");
  a_valid_cause: assert property (REG_RSP.rd_valid |-> $past(REG_REQ.rd_en))
    else $error("read answer without a read");
  a_unmapped_zero: assert property (REG_REQ.rd_en && (REG_REQ.addr < ADDR_SERIAL_PORT ||
    REG_REQ.addr > ADDR_THRESH_CH34) |=> REG_RSP.rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_volume_readback: assert property (s_vol_wr_rd |=> REG_RSP.rd_data == $past(REG_REQ.wr_data, 2))
    else $error("volume read back wrong");
  a_serial_update: assert property (s_wr(ADDR_SERIAL_PORT) |=> SERIAL_CFG == $past(REG_REQ.wr_data))
    else $error("serial setup not updated");
  a_serial_flag: assert property (SERIAL_CFG_RESERVED == (SERIAL_CFG.sample_rate_sel == RATE_RESERVED ||
    SERIAL_CFG.input_format == FMT_RESERVED))
    else $error("serial reserved flag wrong");
  a_state_update: assert property (s_wr(ADDR_CHANNEL_STATE) |=> CH_STATE_SEL == $past(REG_REQ.wr_data))
    else $error("state select not updated");
  a_abort_pulse: assert property (s_wr(ADDR_LOAD_CHECK) ##0 REG_REQ.wr_data[ABORT_BIT] |=> DIAG_ABORT_PULSE)
    else $error("abort write gave no pulse");
  a_abort_blocks: assert property (DIAG_CFG.diag_abort |-> DIAG_START == 4'h0)
    else $error("start while abort held");
  a_mute_level: assert property (CH_MUTE == mute_exp)
    else $error("mute does not follow gain");
  a_thresh_flag: assert property (SHORT_THRESHOLD_RESERVED == thr_exp)
    else $error("threshold reserved flag wrong");
endmodule // aacr_config_regs_chk

bind aacr_config_regs aacr_config_regs_chk u_chk (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .REG_REQ(REG_REQ),
  .REG_RSP(REG_RSP), .SERIAL_CFG(SERIAL_CFG), .SERIAL_CFG_RESERVED(SERIAL_CFG_RESERVED),
  .CH_STATE_SEL(CH_STATE_SEL), .CH_GAIN(CH_GAIN), .CH_MUTE(CH_MUTE), .DIAG_CFG(DIAG_CFG),
  .DIAG_ABORT_PULSE(DIAG_ABORT_PULSE), .DIAG_START(DIAG_START), .SHORT_THRESHOLD(SHORT_THRESHOLD),
  .SHORT_THRESHOLD_RESERVED(SHORT_THRESHOLD_RESERVED));

// ---- verification/aacr_host_model.sv ----
// host controller model driving the register port one byte at a time
// assumes the bench calls its tasks only after reset is released
`timescale 1ns/1ps

module aacr_host_model import aacr_pkg::*; (
  input wire logic CLK_SYS,
  input wire aacr_reg_rsp_type REG_RSP,
  output aacr_reg_req_type REG_REQ
);
  initial REG_REQ = '0; // idle until the first access
  // one write; released address and data are inverted, not held
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: ~d};
  endtask
  // one read; waits a bounded time for the answer marker
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    d = 'x;
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 8'h00};
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: 8'hff};
    // look just past the edge, never in the edge that launches the answer
    for (int i = 0; i < 4; i++) begin
      #1;
      if (REG_RSP.rd_valid === 1'b1) begin
        d = REG_RSP.rd_data;
        break;
      end
      @(posedge CLK_SYS);
    end
  endtask
  // a write and a read of the same offset on back-to-back edges
  task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: d};
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: ~d};
    @(posedge CLK_SYS);
    REG_REQ <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wr_data: ~d};
    #1;
    q = REG_RSP.rd_data;
  endtask
endmodule // aacr_host_model

// ---- verification/audio_amp_config_regs_tb_top.sv ----
// self-checking bench for the amplifier configuration register bank
// assumes the host model and bound checker are compiled beforehand
`timescale 1ns/1ps

module audio_amp_config_regs_tb_top import aacr_pkg::*; ;
  logic clk_sys, arst_n, frame_sync; // clock, reset, frame pulse
  logic [1:0] step_rate; // volume step rate select
  logic [3:0] ch_fault; // per-channel fault levels
  aacr_reg_req_type reg_req;
  aacr_reg_rsp_type reg_rsp;
  aacr_serial_cfg_type serial_cfg;
  aacr_diag_cfg_type diag_cfg;
  logic serial_res, abort_pulse;
  logic [7:0] state_sel;
  logic [31:0] ch_gain;
  logic [3:0] ch_mute, diag_start, thr_res;
  logic [15:0] thr;
  int bad_count, comparisons;

  aacr_host_model host (.CLK_SYS(clk_sys), .REG_RSP(reg_rsp), .REG_REQ(reg_req));
  aacr_config_regs dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_REQ(reg_req), .REG_RSP(reg_rsp),
    .FRAME_SYNC(frame_sync), .VOLUME_STEP_RATE(step_rate), .CH_FAULT(ch_fault), .SERIAL_CFG(serial_cfg),
    .SERIAL_CFG_RESERVED(serial_res), .CH_STATE_SEL(state_sel), .CH_GAIN(ch_gain), .CH_MUTE(ch_mute),
    .DIAG_CFG(diag_cfg), .DIAG_ABORT_PULSE(abort_pulse), .DIAG_START(diag_start),
    .SHORT_THRESHOLD(thr), .SHORT_THRESHOLD_RESERVED(thr_res));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  // returns 1 ns past the taking edge, so outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
    logic [7:0] d;
    host.read_reg(a, d);
    chk(name, e, d);
  endtask
  // one frame pulse, then wait out the two-cycle step latency
  task automatic sync;
    @(posedge clk_sys) frame_sync <= 1'b1;
    @(posedge clk_sys) frame_sync <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic fault(input logic [3:0] v);
    @(posedge clk_sys) ch_fault <= v;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] rv [9] = '{8'h04, 8'h55, 8'hcf, 8'hcf, 8'hcf, 8'hcf, 8'h00, 8'h11, 8'h11};
    for (int i = 0; i < 9; i++) rd(8'(ADDR_SERIAL_PORT + i), rv[i], "reset_value");
    rd(8'h0c, 8'h00, "unmapped_read");
    rd(8'h00, 8'h00, "unmapped_read");
    chk("state_out", 32'h55, {24'h0, state_sel});
    chk("thresh_out", 32'h1111, {16'h0, thr});
    $display("reset values done");
  endtask
  // every rate and format code, with slot bits varied along
  task automatic t_serial;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[0], i[1], i[2], i[2:0]};
      wr(ADDR_SERIAL_PORT, v);
      chk("serial_cfg", {24'h0, v}, {24'h0, serial_cfg});
      chk("serial_res", {31'h0, i[1:0] == 2'b11 || i[2:0] == 3'b111}, {31'h0, serial_res});
    end
    rd(ADDR_SERIAL_PORT, 8'hff, "serial_read");
    wr(ADDR_SERIAL_PORT, 8'h04);
    $display("serial setup done");
  endtask
  // leaving high impedance starts checks unless skipped
  task automatic t_state;
    wr(ADDR_CHANNEL_STATE, 8'h1b);
    chk("diag_start", 32'hd, {28'h0, diag_start});
    chk("state_sel", 32'h1b, {24'h0, state_sel});
    wr(ADDR_LOAD_CHECK, 8'h01);
    wr(ADDR_CHANNEL_STATE, 8'h55);
    wr(ADDR_CHANNEL_STATE, 8'h1b);
    chk("diag_start_skip", 32'h8, {28'h0, diag_start});
    fault(4'b0001);
    chk("fault_start_skip", 32'h0, {28'h0, diag_start});
    fault(4'b0000);
    wr(ADDR_LOAD_CHECK, 8'h00);
    fault(4'b0010);
    chk("fault_start", 32'h2, {28'h0, diag_start});
    fault(4'b0000);
    $display("state control done");
  endtask
  task automatic t_abort;
    wr(ADDR_LOAD_CHECK, 8'h80);
    chk("abort_pulse", 32'h1, {31'h0, abort_pulse});
    fault(4'b0100);
    chk("start_in_abort", 32'h0, {28'h0, diag_start});
    fault(4'b0000);
    wr(ADDR_LOAD_CHECK, 8'h00);
    chk("abort_quiet", 32'h0, {31'h0, abort_pulse});
    fault(4'b0100);
    chk("start_after_abort", 32'h4, {28'h0, diag_start});
    fault(4'b0000);
    wr(ADDR_LOAD_CHECK, 8'h62);
    chk("diag_cfg", 32'h62, {24'h0, diag_cfg});
    rd(ADDR_LOAD_CHECK, 8'h62, "diag_read");
    wr(ADDR_LOAD_CHECK, 8'h00);
    $display("abort done");
  endtask
  task automatic t_thresh;
    wr(ADDR_THRESH_CH12, 8'h9a);
    wr(ADDR_THRESH_CH34, 8'h0f);
    chk("thresh", 32'h9a0f, {16'h0, thr});
    chk("thresh_res", 32'ha, {28'h0, thr_res});
    rd(ADDR_THRESH_CH34, 8'h0f, "thresh_read");
    $display("thresholds done");
  endtask
  // each rate waits 1, 2, 4, 8 frames per step; then ramp to mute edge
  task automatic t_volume;
    logic [7:0] tv [4] = '{8'hd3, 8'h06, 8'h07, 8'hff};
    logic [7:0] g;
    host.write_read(ADDR_VOLUME_FIRST, 8'hd3, g);
    chk("volume_wr_rd", 32'hd3, {24'h0, g});
    for (int i = 0; i < 4; i++) wr(8'(ADDR_VOLUME_FIRST + i), tv[i]);
    for (int i = 0; i < 4; i++) rd(8'(ADDR_VOLUME_FIRST + i), tv[i], "volume_read");
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_sys) step_rate <= 2'(r);
      g = ch_gain[7:0];
      for (int k = 1; k <= (1 << r); k++) begin
        sync();
        chk("ramp_gain", {24'h0, k == (1 << r) ? 8'(g + 1) : g}, {24'h0, ch_gain[7:0]});
      end
    end
    @(posedge clk_sys) step_rate <= 2'd0;
    repeat (200) sync();
    chk("final_gain", 32'hff0706d3, ch_gain);
    chk("mute", 32'h2, {28'h0, ch_mute});
    $display("volume done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    frame_sync = 1'b0;
    step_rate = 2'd0;
    ch_fault = 4'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_serial();
    t_state();
    t_abort();
    t_thresh();
    t_volume();
    conclude();
  end
  // whole run is about 760 cycles; this limit leaves wide margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end
endmodule // audio_amp_config_regs_tb_top
